/* File: hdl/fcdp_pkg.sv */
package fcdp_pkg;

  // clock and rate figures
  localparam int SYS_CLK_MHZ    = 40;
  localparam int SER_MAX_MHZ    = 66;
  localparam int PAR_MAX_MHZ    = 19;
  localparam int RATE_2CH_MHZ   = 66;
  localparam int RATE_4CH_MHZ   = 38;
  localparam int RATE_8CH_MHZ   = 19;

  // clear pulse and done wait
  localparam int CLEAR_PULSE_NS = 500;
  localparam int CLEAR_CYCLES   = (CLEAR_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int DONE_CLOCKS    = 64;

  // widths
  localparam int BYTE_W         = 8;
  localparam int MAX_TARGETS    = 4;
  localparam int PER_W          = 4;

  // target mode codes
  localparam logic [2:0] MODE_SERIAL   = 3'h7;
  localparam logic [2:0] MODE_PARALLEL = 3'h6;

  // chain count tiers
  localparam logic [3:0] CH_TIER1 = 4'h2;
  localparam logic [3:0] CH_TIER2 = 4'h4;
  localparam logic [3:0] CH_MAX   = 4'h8;

  // shortest clock period in system cycles, never under two phases
  function automatic int min_period(input int mhz);
    int p;
    p = (SYS_CLK_MHZ + mhz - 1) / mhz;
    return (p < 2) ? 2 : p;
  endfunction

  localparam logic [PER_W-1:0] SER_PERIOD = PER_W'(min_period(SER_MAX_MHZ));
  localparam logic [PER_W-1:0] PER_2CH    = PER_W'(min_period(RATE_2CH_MHZ));
  localparam logic [PER_W-1:0] PER_4CH    = PER_W'(min_period(RATE_4CH_MHZ));
  localparam logic [PER_W-1:0] PER_8CH    = PER_W'(min_period(RATE_8CH_MHZ));
  localparam logic [PER_W-1:0] PAR_PERIOD = PER_W'(min_period(PAR_MAX_MHZ));

  // per-chain clock period for a chain count
  function automatic logic [PER_W-1:0] chain_period(input logic [3:0] n);
    if (n <= CH_TIER1) return PER_2CH;
    else if (n <= CH_TIER2) return PER_4CH;
    else return PER_8CH;
  endfunction

  // interleaved slices held by one stored byte
  function automatic logic [3:0] slices_per_byte(input logic [3:0] n);
    case (n)
      4'h1:       return 4'h8;
      4'h2:       return 4'h4;
      4'h3, 4'h4: return 4'h2;
      default:    return 4'h1;
    endcase
  endfunction

  typedef enum logic [6:0] {
    ST_IDLE      = 7'h01,
    ST_CLEAR     = 7'h02,
    ST_WAIT_INIT = 7'h04,
    ST_LOAD      = 7'h08,
    ST_WAIT_DONE = 7'h10,
    ST_DONE_OK   = 7'h20,
    ST_DONE_FAIL = 7'h40
  } fcdp_state_e;

endpackage

/* File: hdl/fcdp_clkdiv.sv */
module fcdp_clkdiv (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  // control
  input  wire logic                      run,
  input  wire logic [fcdp_pkg::PER_W-1:0] period,
  input  wire logic                      rise_ok,
  // timing
  output logic                           fall_en,
  output logic                           rise_en,
  output logic                           clk_out
);

  logic [fcdp_pkg::PER_W-1:0] cnt_r;

  // phase points of one target clock period
  assign fall_en = run && (cnt_r == '0);
  assign rise_en = run && (cnt_r == (period >> 1));

  // period counter, parked at zero while stopped
  always_ff @(posedge sys_clk) begin
    if (!resetn || !run) begin
      cnt_r <= '0;
    end else if (cnt_r == period - 4'h1) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // clock pin: rises only when rise_ok is high (data ready during delivery, or at every rise during the done wait)
  always_ff @(posedge sys_clk) begin
    if (!resetn || !run) begin
      clk_out <= 1'b0;
    end else if (rise_en && rise_ok) begin
      clk_out <= 1'b1;
    end else if (fall_en) begin
      clk_out <= 1'b0;
    end
  end

endmodule

/* File: hdl/fcdp_slicer.sv */
module fcdp_slicer #(
  parameter int BYTE_W = fcdp_pkg::BYTE_W
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // control
  input  wire logic              flush,
  input  wire logic [3:0]        width,
  input  wire logic              load,
  input  wire logic              advance,
  input  wire logic [BYTE_W-1:0] byte_in,
  // result
  output logic [BYTE_W-1:0]      data_out,
  output logic                   more
);

  logic [BYTE_W-1:0] byte_r;
  logic [2:0]        idx_r;
  logic              have_r;
  logic [3:0]        slices;

  // slice idx of a byte: chain k takes bit idx*width+k, unused bits zero
  function automatic logic [BYTE_W-1:0] pick(input logic [BYTE_W-1:0] b,
                                             input logic [2:0] idx,
                                             input logic [3:0] w);
    logic [BYTE_W-1:0] s;
    logic [BYTE_W-1:0] r;
    s = b >> (int'(idx) * int'(w));
    for (int k = 0; k < BYTE_W; k++) begin
      r[k] = (k < int'(w)) ? s[k] : 1'b0;
    end
    return r;
  endfunction

  // slices left in the held byte
  assign slices = fcdp_pkg::slices_per_byte(width);
  assign more   = have_r && (({1'b0, idx_r} + 4'h1) < slices);

  // byte hold and slice walk
  always_ff @(posedge sys_clk) begin
    if (!resetn || flush) begin
      byte_r   <= '0;
      idx_r    <= '0;
      have_r   <= 1'b0;
      data_out <= '0;
    end else if (load) begin
      byte_r   <= byte_in;
      idx_r    <= '0;
      have_r   <= 1'b1;
      data_out <= pick(byte_in, 3'h0, width);
    end else if (advance && more) begin
      idx_r    <= idx_r + 3'h1;
      data_out <= pick(byte_r, idx_r + 3'h1, width);
    end
  end

endmodule

/* File: hdl/fcdp_config_port.sv */
module fcdp_config_port #(
  parameter int DONE_CLOCKS = fcdp_pkg::DONE_CLOCKS
) (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         resetn,
  // run control
  input  wire logic                         start,
  input  wire logic                         parallel_sel,
  input  wire logic [3:0]                   chain_count,
  input  wire logic [2:0]                   target_count,
  // stored stream
  input  wire logic [fcdp_pkg::BYTE_W-1:0]  stream_data,
  input  wire logic                         stream_valid,
  input  wire logic                         stream_last,
  output logic                              stream_ready,
  // status
  output logic                              cfg_active,
  output logic                              cfg_success,
  output logic                              cfg_error,
  // target pins
  output logic                              target_config_clock,
  output logic [fcdp_pkg::BYTE_W-1:0]       cfg_data,
  output logic [2:0]                        cfg_mode,
  output logic                              target_clear_pulse_n,
  output logic                              cfg_rw_n,
  output logic [fcdp_pkg::MAX_TARGETS-1:0]  cfg_cs_n,
  input  wire logic                         cfg_init_pin,
  input  wire logic                         cfg_done_pin,
  input  wire logic                         cfg_busy_pin
);

  localparam int CLR_D    = fcdp_pkg::CLEAR_CYCLES;
  localparam int CLR_REST = CLR_D - 7;
  localparam int CLR_W    = $clog2(CLR_D + 1);
  localparam int DN_W     = $clog2(DONE_CLOCKS + 1);
  localparam logic [3:0] SER_P = fcdp_pkg::SER_PERIOD;
  localparam logic [3:0] PAR_P = fcdp_pkg::PAR_PERIOD;

  fcdp_pkg::fcdp_state_e state_r;
  logic [2:0]            sync1_r;
  logic [2:0]            sync2_r;
  logic                  init_s;
  logic                  done_s;
  logic                  busy_s;
  logic                  par_r;
  logic [3:0]            width_r;
  logic [1:0]            tcount_r;
  logic [1:0]            tgt_r;
  logic [CLR_W-1:0]      clr_cnt_r;
  logic [DN_W-1:0]       done_cnt_r;
  logic                  last_r;
  logic                  hold_r;
  logic                  bit_ok_r;
  logic                  start_ok;
  logic                  in_load;
  logic                  run;
  logic                  rise_ok;
  logic                  fall_en;
  logic                  rise_en;
  logic                  sh_more;
  logic                  take;
  logic                  advance;
  logic                  end_tgt;
  logic [3:0]            period_sel;

  // chain count clamped to one..eight
  function automatic logic [3:0] clamp_chains(input logic [3:0] n);
    if (n == 4'h0) return 4'h1;
    else if (n > fcdp_pkg::CH_MAX) return fcdp_pkg::CH_MAX;
    else return n;
  endfunction

  // target count to last select index, one..four
  function automatic logic [1:0] clamp_targets(input logic [2:0] n);
    if (n == 3'h0) return 2'h0;
    else if (n > 3'h4) return 2'h3;
    else return 2'(n - 3'h1);
  endfunction

  // pin inputs through two flip-flops
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {cfg_busy_pin, cfg_done_pin, cfg_init_pin};
      sync2_r <= sync1_r;
    end
  end
  assign init_s = sync2_r[0];
  assign done_s = sync2_r[1];
  assign busy_s = sync2_r[2];

  // start only from rest
  assign start_ok = start && (state_r == fcdp_pkg::ST_IDLE ||
                              state_r == fcdp_pkg::ST_DONE_OK ||
                              state_r == fcdp_pkg::ST_DONE_FAIL);

  // run setup caught at start
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      par_r    <= 1'b0;
      width_r  <= 4'h1;
      tcount_r <= 2'h0;
    end else if (start_ok) begin
      par_r    <= parallel_sel;
      width_r  <= parallel_sel ? fcdp_pkg::CH_MAX : clamp_chains(chain_count);
      tcount_r <= clamp_targets(target_count);
    end
  end

  // clock rate: parallel cap or chain tier
  assign period_sel = par_r ? PAR_P : fcdp_pkg::chain_period(width_r);
  assign in_load    = (state_r == fcdp_pkg::ST_LOAD);
  assign run        = in_load || (state_r == fcdp_pkg::ST_WAIT_DONE);
  assign rise_ok    = (in_load && bit_ok_r) || (state_r == fcdp_pkg::ST_WAIT_DONE);

  fcdp_clkdiv u_div (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .run     (run),
    .period  (period_sel),
    .rise_ok (rise_ok),
    .fall_en (fall_en),
    .rise_en (rise_en),
    .clk_out (target_config_clock)
  );

  // delivery decisions at the falling phase
  assign stream_ready = in_load && fall_en && !hold_r && !sh_more && !last_r;
  assign take         = stream_ready && stream_valid;
  assign advance      = in_load && fall_en && !hold_r && sh_more;
  assign end_tgt      = in_load && fall_en && !hold_r && !sh_more && last_r;

  fcdp_slicer u_slice (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .flush    (start_ok),
    .width    (width_r),
    .load     (take),
    .advance  (advance),
    .byte_in  (stream_data),
    .data_out (cfg_data),
    .more     (sh_more)
  );

  // data ready for the next rise
  always_ff @(posedge sys_clk) begin
    if (!resetn || !in_load) begin
      bit_ok_r <= 1'b0;
    end else if (fall_en) begin
      bit_ok_r <= hold_r || sh_more || take;
    end
  end

  // busy seen at a rise in parallel mode keeps the byte for another clock
  always_ff @(posedge sys_clk) begin
    if (!resetn || !in_load) begin
      hold_r <= 1'b0;
    end else if (rise_en && bit_ok_r) begin
      hold_r <= par_r && busy_s;
    end
  end

  // end-of-stream mark for the current target
  always_ff @(posedge sys_clk) begin
    if (!resetn || start_ok) begin
      last_r <= 1'b0;
    end else if (take) begin
      last_r <= stream_last;
    end else if (end_tgt) begin
      last_r <= 1'b0;
    end
  end

  // target index walks upward from select 0
  always_ff @(posedge sys_clk) begin
    if (!resetn || start_ok) begin
      tgt_r <= 2'h0;
    end else if (end_tgt && par_r && tgt_r != tcount_r) begin
      tgt_r <= tgt_r + 2'h1;
    end
  end

  // clear pulse length
  always_ff @(posedge sys_clk) begin
    if (!resetn || state_r != fcdp_pkg::ST_CLEAR) begin
      clr_cnt_r <= '0;
    end else begin
      clr_cnt_r <= clr_cnt_r + CLR_W'(1);
    end
  end

  // target clocks spent waiting for done
  always_ff @(posedge sys_clk) begin
    if (!resetn || state_r != fcdp_pkg::ST_WAIT_DONE) begin
      done_cnt_r <= '0;
    end else if (rise_en) begin
      done_cnt_r <= done_cnt_r + DN_W'(1);
    end
  end

  // sequence control
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r <= fcdp_pkg::ST_IDLE;
    end else begin
      case (state_r)
        fcdp_pkg::ST_IDLE, fcdp_pkg::ST_DONE_OK, fcdp_pkg::ST_DONE_FAIL: begin
          if (start_ok) state_r <= fcdp_pkg::ST_CLEAR;
        end
        fcdp_pkg::ST_CLEAR: begin
          if (clr_cnt_r == CLR_W'(CLR_D - 1)) state_r <= fcdp_pkg::ST_WAIT_INIT;
        end
        fcdp_pkg::ST_WAIT_INIT: begin
          if (init_s) state_r <= fcdp_pkg::ST_LOAD;
        end
        fcdp_pkg::ST_LOAD: begin
          if (end_tgt && (!par_r || tgt_r == tcount_r)) state_r <= fcdp_pkg::ST_WAIT_DONE;
        end
        fcdp_pkg::ST_WAIT_DONE: begin
          if (done_s) begin
            state_r <= fcdp_pkg::ST_DONE_OK;
          end else if (rise_en && done_cnt_r == DN_W'(DONE_CLOCKS - 1)) begin
            state_r <= fcdp_pkg::ST_DONE_FAIL;
          end
        end
        default: state_r <= fcdp_pkg::ST_IDLE;
      endcase
    end
  end

  // shared control pins and status
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      target_clear_pulse_n <= 1'b1;
      cfg_rw_n             <= 1'b1;
      cfg_mode             <= fcdp_pkg::MODE_SERIAL;
      cfg_active           <= 1'b0;
      cfg_success          <= 1'b0;
      cfg_error            <= 1'b0;
    end else begin
      target_clear_pulse_n <= (state_r != fcdp_pkg::ST_CLEAR);
      cfg_rw_n             <= !(par_r && run);
      if (start_ok) begin
        cfg_mode <= parallel_sel ? fcdp_pkg::MODE_PARALLEL : fcdp_pkg::MODE_SERIAL;
      end
      cfg_active  <= !(state_r == fcdp_pkg::ST_IDLE || state_r == fcdp_pkg::ST_DONE_OK ||
                       state_r == fcdp_pkg::ST_DONE_FAIL);
      cfg_success <= (state_r == fcdp_pkg::ST_DONE_OK);
      cfg_error   <= (state_r == fcdp_pkg::ST_DONE_FAIL);
    end
  end

  // one active-low select per target
  for (genvar k = 0; k < fcdp_pkg::MAX_TARGETS; k++) begin : g_cs
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        cfg_cs_n[k] <= 1'b1;
      end else begin
        cfg_cs_n[k] <= !(par_r && in_load && tgt_r == 2'(k));
      end
    end
  end

  // checking helpers: cycles between target clock rises
  logic       clk_prev_r;
  logic [3:0] gap_r;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      clk_prev_r <= 1'b0;
      gap_r      <= 4'hF;
    end else begin
      clk_prev_r <= target_config_clock;
      if (target_config_clock && !clk_prev_r) gap_r <= 4'h1;
      else if (gap_r != 4'hF) gap_r <= gap_r + 4'h1;
    end
  end

  // chain mask of the active width
  function automatic logic [fcdp_pkg::BYTE_W-1:0] chain_mask(input logic [3:0] w);
    logic [fcdp_pkg::BYTE_W:0] m;
    m = ({{fcdp_pkg::BYTE_W{1'b0}}, 1'b1} << w) - 1'b1;
    return m[fcdp_pkg::BYTE_W-1:0];
  endfunction

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_SER_RATE: assert property ($rose(target_config_clock) && !par_r |-> gap_r >= SER_P)
    else $error("serial target clock too fast");
  AST_PAR_RATE: assert property ($rose(target_config_clock) && par_r |-> gap_r >= PAR_P)
    else $error("parallel target clock too fast");
  AST_CLEAR_LEN: assert property ($fell(target_clear_pulse_n) |->
      (!target_clear_pulse_n)[*8] ##CLR_REST target_clear_pulse_n)
    else $error("clear pulse length wrong");
  AST_INIT_GATE: assert property ($rose(state_r == fcdp_pkg::ST_LOAD) |-> $past(init_s))
    else $error("delivery began before init high");
  AST_DONE_OK: assert property (state_r == fcdp_pkg::ST_WAIT_DONE && done_s
      |-> ##2 cfg_success)
    else $error("done high did not report success");
  AST_BUSY_HOLD: assert property (in_load && fall_en && hold_r |=> $stable(cfg_data))
    else $error("byte changed while target busy");
  AST_CS_ONE: assert property ($countones(~cfg_cs_n) <= 1)
    else $error("more than one target selected");
  AST_SER_NO_CS: assert property (!par_r |-> &cfg_cs_n)
    else $error("select driven in serial mode");
  AST_RW_WITH_CS: assert property (!(&cfg_cs_n) |-> !cfg_rw_n)
    else $error("select without write direction");
  AST_CHAIN_BITS: assert property (in_load && !par_r |->
      (cfg_data & ~chain_mask(width_r)) == '0)
    else $error("data on an unused chain bit");
  AST_MODE_PINS: assert property (cfg_active |-> cfg_mode == (par_r ?
      fcdp_pkg::MODE_PARALLEL : fcdp_pkg::MODE_SERIAL))
    else $error("mode pins do not match delivery");

  COV_SER_OK: cover property (!par_r && width_r > 4'h1 && $rose(cfg_success));
  COV_PAR_OK: cover property (par_r && tcount_r != 2'h0 && $rose(cfg_success));
  COV_BUSY: cover property (in_load && fall_en && hold_r);
  COV_FAIL: cover property ($rose(cfg_error));

endmodule

/* File: bench/fcdp_target_model.sv */
module fcdp_target_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // pins from the port
  input  wire logic        clear_n,
  input  wire logic        fpga_config_clock_input,
  input  wire logic [7:0]  data,
  input  wire logic [3:0]  cs_n,
  input  wire logic        rw_n,
  // bench control
  input  wire logic [15:0] done_at,
  input  wire logic [15:0] busy_at,
  // pins back to the port
  output logic             init_pin,
  output logic             done_pin,
  output logic             busy_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        fpga_config_clock_input_d_r;
  int          cyc_r;
  int          rises_r;
  int          busy_left_r;
  int          init_left_r;
  logic [12:0] rec_q[$];
  int          rise_t[$];

  // targets share clock and controls; chain k reads bit k, target k answers to select k
  always @(posedge sys_clk) begin
    cyc_r <= cyc_r + 1;
    fpga_config_clock_input_d_r <= fpga_config_clock_input;
    if (!resetn || !clear_n) begin
      rises_r <= 0;
      done_pin <= 1'b0;
      busy_pin <= 1'b0;
      busy_left_r <= 0;
      init_pin <= 1'b0;
      init_left_r <= 4;
      rec_q.delete();
      rise_t.delete();
    end else begin
      // init rises a few cycles after the clear pulse ends
      if (init_left_r > 0) init_left_r <= init_left_r - 1;
      else init_pin <= 1'b1;
      // every rising target clock is logged with the bus state it sampled
      if (fpga_config_clock_input && !fpga_config_clock_input_d_r) begin
        rec_q.push_back({rw_n, cs_n, data});
        rise_t.push_back(cyc_r);
        rises_r <= rises_r + 1;
        if (rises_r + 1 == int'(done_at)) done_pin <= 1'b1;
        if (rises_r + 1 == int'(busy_at)) begin
          busy_pin <= 1'b1;
          busy_left_r <= 8;
        end
      end
      // busy stays up for eight cycles
      if (busy_left_r == 1) busy_pin <= 1'b0;
      if (busy_left_r > 0) busy_left_r <= busy_left_r - 1;
    end
  end
endmodule

/* File: bench/tb_top.sv */
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0;
  logic        resetn, start, parallel_sel, stream_valid, stream_last, stream_ready;
  logic [3:0]  chain_count;
  logic [2:0]  target_count;
  logic [7:0]  stream_data, cfg_data;
  logic        cfg_active, cfg_success, cfg_error, target_config_clock;
  logic [2:0]  cfg_mode;
  logic        target_clear_pulse_n, cfg_rw_n, init_w, done_w, busy_w;
  logic [3:0]  cfg_cs_n;
  logic [15:0] done_at, busy_at;
  int          err_total = 0;
  int          num_checks = 0;

  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  fcdp_config_port #(.DONE_CLOCKS(8)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .start(start), .parallel_sel(parallel_sel),
    .chain_count(chain_count), .target_count(target_count), .stream_data(stream_data),
    .stream_valid(stream_valid), .stream_last(stream_last), .stream_ready(stream_ready),
    .cfg_active(cfg_active), .cfg_success(cfg_success), .cfg_error(cfg_error),
    .target_config_clock(target_config_clock), .cfg_data(cfg_data), .cfg_mode(cfg_mode),
    .target_clear_pulse_n(target_clear_pulse_n), .cfg_rw_n(cfg_rw_n), .cfg_cs_n(cfg_cs_n),
    .cfg_init_pin(init_w), .cfg_done_pin(done_w), .cfg_busy_pin(busy_w));

  fcdp_target_model tgt (
    .sys_clk(sys_clk), .resetn(resetn), .clear_n(target_clear_pulse_n),
    .fpga_config_clock_input(target_config_clock), .data(cfg_data), .cs_n(cfg_cs_n), .rw_n(cfg_rw_n),
    .done_at(done_at), .busy_at(busy_at), .init_pin(init_w), .done_pin(done_w),
    .busy_pin(busy_w));

  // counts and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // slices per stored byte and clock period for a chain count at 40 MHz
  function automatic int spb(input int n);
    return (n == 1) ? 8 : (n == 2) ? 4 : (n <= 4) ? 2 : 1;
  endfunction
  function automatic int per(input int n);
    return (n <= 4) ? 2 : 3;
  endfunction

  // start a run, then measure the clear pulse
  task automatic begin_run(input logic par, input logic [3:0] n, input int d, input int b);
    int lc;
    lc = 0;
    @(posedge sys_clk);
    parallel_sel <= par;
    chain_count <= n;
    target_count <= n[2:0];
    done_at <= 16'(d);
    busy_at <= 16'(b);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    while (target_clear_pulse_n && lc < 10) begin
      @(negedge sys_clk);
      lc++;
    end
    lc = 0;
    while (!target_clear_pulse_n && lc < 100) begin
      @(negedge sys_clk);
      lc++;
    end
    `CHK("clear length", fcdp_pkg::CLEAR_CYCLES, lc)
    `CHK("active", 1'b1, cfg_active)
    `CHK("mode", par ? fcdp_pkg::MODE_PARALLEL : fcdp_pkg::MODE_SERIAL, cfg_mode)
  endtask

  // offer one byte and hold it until taken
  task automatic send_byte(input logic [7:0] b, input logic last, input int gap);
    int k;
    k = 0;
    repeat (gap + 1) @(posedge sys_clk);
    stream_data <= b;
    stream_valid <= 1'b1;
    stream_last <= last;
    do begin
      @(negedge sys_clk);
      k++;
    end while (stream_ready !== 1'b1 && k < 300);
    `CHK("byte taken", 1'b1, stream_ready)
    @(posedge sys_clk);
    stream_valid <= 1'b0;
    stream_last <= 1'b0;
  endtask

  // wait for the run verdict
  task automatic wait_end(input logic ok);
    int k;
    k = 0;
    while (cfg_success !== 1'b1 && cfg_error !== 1'b1 && k < 3000) begin
      @(negedge sys_clk);
      k++;
    end
    `CHK("success", ok, cfg_success)
    `CHK("error", ~ok, cfg_error)
    `CHK("active", 1'b0, cfg_active)
    `CHK("selects idle", 4'hF, cfg_cs_n)
  endtask

  // serial run with n chains, optional source stall before the second byte
  task automatic test_serial(input logic [3:0] n, input int gap);
    logic [7:0] bytes [3];
    logic [7:0] ex;
    int         s;
    int         nr;
    bytes = '{8'hA5, 8'h3C, 8'h96};
    s = spb(n);
    nr = 3 * s;
    begin_run(1'b0, n, nr + 1, 0);
    // every chain gets the same number of bits
    for (int i = 0; i < 3; i++) send_byte(bytes[i], i == 2, (i == 1) ? gap : 0);
    wait_end(1'b1);
    for (int j = 0; j < nr; j++) begin
      ex = 8'h00;
      for (int k = 0; k < n; k++) ex[k] = bytes[j / s][(j % s) * n + k];
      `CHK("chain bits", {1'b1, 4'hF, ex}, tgt.rec_q[j])
    end
    `CHK("chain period", per(n), tgt.rise_t[1] - tgt.rise_t[0])
    $display("serial test with %0d chains finished", n);
  endtask

  // three parallel targets, busy raised during the first target
  task automatic test_parallel();
    logic [12:0] got[$];
    logic [12:0] ew;
    int          mn;
    int          nl;
    mn = 99;
    nl = 0;
    begin_run(1'b1, 4'h3, 13, 2);
    for (int t = 0; t < 3; t++)
      for (int i = 0; i < 3; i++) send_byte(8'(8'h10 * (t + 1) + i), i == 2, 0);
    wait_end(1'b1);
    for (int j = 0; j < tgt.rec_q.size(); j++) begin
      if (j > 0 && tgt.rise_t[j] - tgt.rise_t[j - 1] < mn) mn = tgt.rise_t[j] - tgt.rise_t[j - 1];
      if (tgt.rec_q[j][11:8] != 4'hF) nl++;
      if (tgt.rec_q[j][11:8] != 4'hF && (got.size() == 0 || got[$] != tgt.rec_q[j]))
        got.push_back(tgt.rec_q[j]);
    end
    `CHK("target words", 9, got.size())
    for (int j = 0; j < 9; j++) begin
      ew = {1'b0, ~(4'h1 << (j / 3)), 8'(8'h10 * (j / 3 + 1) + j % 3)};
      `CHK("bus word", ew, got[j])
    end
    `CHK("busy hold", 1'b1, nl > 9)
    `CHK("parallel clock spacing", 1'b1, mn >= 3)
    $display("parallel test finished");
  endtask

  // done never rises; a start in mid-run is ignored
  task automatic test_fail();
    begin_run(1'b0, 4'h1, 0, 0);
    send_byte(8'h5A, 1'b1, 0);
    @(posedge sys_clk);
    parallel_sel <= 1'b1;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    @(negedge sys_clk);
    `CHK("mode kept", fcdp_pkg::MODE_SERIAL, cfg_mode)
    wait_end(1'b0);
    $display("done failure test finished");
  endtask

  // main sequence
  initial begin
    resetn = 1'b0;
    start = 1'b0;
    parallel_sel = 1'b0;
    chain_count = 4'h0;
    target_count = 3'h0;
    stream_data = 8'h00;
    stream_valid = 1'b0;
    stream_last = 1'b0;
    done_at = 16'h0000;
    busy_at = 16'h0000;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    `CHK("reset clear", 1'b1, target_clear_pulse_n)
    `CHK("reset selects", 4'hF, cfg_cs_n)
    test_serial(4'h1, 0);
    test_serial(4'h2, 4);
    test_serial(4'h3, 0);
    test_serial(4'h5, 0);
    test_serial(4'h8, 0);
    test_parallel();
    test_fail();
    summarize();
  end

  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #(25 * 20000);
    err_total++;
    summarize();
  end
endmodule
